// >>> design/spi_xfer_regs.vh
// Constants for the SPI transfer engine: control bit positions, rates, timing
`ifndef SPI_XFER_REGS_VH
`define SPI_XFER_REGS_VH

// ************************************************************
// Control register bit positions
// ************************************************************
`define CTL_IRQ_EN_BIT 7
`define CTL_PERIPH_EN_BIT 6
`define CTL_DIV_EN_BIT 5
`define CTL_MASTER_BIT 4
`define CTL_CPOL_BIT 3
`define CTL_CPHA_BIT 2
`define CTL_RATE_HI_BIT 1
`define CTL_RATE_LO_BIT 0
`define CTL_RESET_VAL 8'h00

// ************************************************************
// Status register bit positions
// ************************************************************
`define STS_DONE_BIT 7
`define STS_WRITE_COLLISION_FLAG_BIT 6
`define STS_MODE_FAULT_FLAG_BIT 4
`define STS_RESET_VAL 8'h00

// ************************************************************
// Serial clock half periods in CPU cycles, indexed by {div_en, hi, lo}
// ************************************************************
`define HALF_DIV4 7'd2
`define HALF_DIV8 7'd4
`define HALF_DIV16 7'd8
`define HALF_DIV32 7'd16
`define HALF_DIV64 7'd32
`define HALF_DIV128 7'd64
`define BITS_PER_XFER 4'd8
`define FIFO_DEPTH 8

`endif

// >>> design/rate_divider.v
// Serial clock half-period tick generator for master mode
`timescale 1ns/10ps
`default_nettype none

module rate_divider (
   input wire clk, // CPU clock
   input wire rstn, // Async reset, active low
   input wire run, // Count while high, restart when low
   input wire [6:0] half_len, // Half period in CPU cycles
   output reg tick // One-cycle pulse at each half period
);

   reg [6:0] cnt_q;

   // Counter restarts on every new byte so the first edge lands a full half later
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 7'h00;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= 7'h00;
         tick <= 1'b0;
      end else if (cnt_q == half_len - 7'h01) begin
         cnt_q <= 7'h00;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 7'h01;
         tick <= 1'b0;
      end
   end

endmodule // rate_divider

`default_nettype wire

// >>> design/byte_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk, // CPU clock
   input wire rstn, // Async reset, active low
   input wire in_valid, // Write side has data
   output wire in_ready, // Room for one more word
   input wire [WIDTH-1:0] in_data, // Write data
   output wire out_valid, // Read side has data
   input wire out_ready, // Read side takes a word
   output wire [WIDTH-1:0] out_data // Head word
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage written only, never reset, to keep it plain flip-flops
   always @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and fill level
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule // byte_fifo

`default_nettype wire

// >>> design/spi_xfer.v
// SPI transfer engine with collision, mode-fault and buffered receive logic
// How it works
// - Each byte shifts out and in together over exactly eight clock pulses.
// - Polarity sets the idle level of the serial clock, master or slave.
// - Phase one captures the first bit on the second clock edge.
// - Phase zero captures the first bit on the first clock edge.
// - Master puts each bit out one edge before it is captured.
// - A low select on a phase-zero slave freezes the data register against writes.
// - A write during a transfer is dropped and flags a write collision.
// - Slave phase one: first clock edge drives the top bit, not select.
// - Slave phase zero: any data write after select low is a collision.
// - Master: a data write while the clock runs is a collision.
// - Write collision never raises an interrupt; software sequence clears it.
// - Select low in master mode flags fault, drops enable and master.
// - Fault clears on status access while set, then control write.
// - Enable and master cannot be set while fault stands, except clearing write.
// - Fault is never newly set in slave mode; an old one may stay.
// - On overrun the buffer keeps the first byte; later bytes lost silently.
// - Received data is read from a CPU-synchronous buffer.
// - Wait mode runs on and events wake; halt freezes registers; synchronisers, pin enables, request and wake keep updating.
// - Done and fault share one request gated by enable and global mask.
// - Top bit first; at the end the byte is buffered and done set.
// - Done clears on status access then data access; writes refused meanwhile.
// - Divider enable and two rate bits pick six master rates.
// - Only a data write starts a master byte.
`timescale 1ns/10ps
`default_nettype none
`include "spi_xfer_regs.vh"

module spi_xfer (
   input wire clk, // CPU clock, 100 MHz
   input wire rstn, // Async reset, active low
   input wire [7:0] wr_data, // CPU write data
   input wire data_wr, // Data register write strobe
   input wire data_rd, // Data register read strobe
   input wire ctrl_wr, // Control register write strobe
   input wire status_acc, // Status register read or write strobe
   input wire global_mask, // CPU global interrupt mask, high blocks
   input wire halt_mode, // High freezes engine and registers; synchronisers, pin enables, irq and wake run on
   input wire wait_mode, // CPU waiting; block keeps running
   output reg [7:0] rx_byte, // Buffered received byte
   output reg [7:0] control_reg, // Control register image
   output reg [7:0] status_reg, // Status register image
   output reg irq, // Shared interrupt request
   output reg wake, // Wake request in wait mode
   input wire sck_in, // Serial clock pin input
   output reg sck_out, // Serial clock pin output
   output reg sck_oe_n, // Serial clock output enable, low drives
   input wire mosi_in, // MOSI pin input
   output reg mosi_out, // MOSI pin output
   output reg mosi_oe_n, // MOSI output enable, low drives
   input wire miso_in, // MISO pin input
   output reg miso_out, // MISO pin output
   output reg miso_oe_n, // MISO output enable, low drives
   input wire ss_n_in, // Slave select pin, active low
   output reg busy // Byte in progress
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   reg [1:0] sck_s_q, mosi_s_q, miso_s_q, ss_s_q;
   reg sck_prev_q;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_s_q <= 2'b00;
         mosi_s_q <= 2'b00;
         miso_s_q <= 2'b00;
         ss_s_q <= 2'b11;
         sck_prev_q <= 1'b0;
      end else begin
         sck_s_q <= {sck_s_q[0], sck_in};
         mosi_s_q <= {mosi_s_q[0], mosi_in};
         miso_s_q <= {miso_s_q[0], miso_in};
         ss_s_q <= {ss_s_q[0], ss_n_in};
         sck_prev_q <= sck_s_q[1];
      end
   end

   wire sck_i = sck_s_q[1];
   wire ss_low = !ss_s_q[1];
   wire run_en = !halt_mode; // Halt freezes registers
   wire en = control_reg[`CTL_PERIPH_EN_BIT];
   wire mst = control_reg[`CTL_MASTER_BIT];
   wire cpol = control_reg[`CTL_CPOL_BIT];
   wire cpha = control_reg[`CTL_CPHA_BIT];
   wire done_f = status_reg[`STS_DONE_BIT];
   wire mode_fault_flag_f = status_reg[`STS_MODE_FAULT_FLAG_BIT];

   // ************************************************************
   // Rate selection and divider
   // ************************************************************
   reg [6:0] half_len;

   // Six rates from {divider_enable, rate_sel_hi, rate_sel_lo}
   always @* begin
      case ({control_reg[`CTL_DIV_EN_BIT], control_reg[`CTL_RATE_HI_BIT],
             control_reg[`CTL_RATE_LO_BIT]})
         3'b100: half_len = `HALF_DIV4;
         3'b000: half_len = `HALF_DIV8;
         3'b001: half_len = `HALF_DIV16;
         3'b110: half_len = `HALF_DIV32;
         3'b010: half_len = `HALF_DIV64;
         3'b011: half_len = `HALF_DIV128;
         default: half_len = `HALF_DIV128; // Unlisted codes take the slowest rate
      endcase
   end

   wire m_tick;
   rate_divider u_div (
      .clk(clk),
      .rstn(rstn),
      .run(busy && mst && run_en),
      .half_len(half_len),
      .tick(m_tick)
   );

   // ************************************************************
   // Receive buffer FIFO; holds the first byte on overrun
   // ************************************************************
   reg push_q;
   reg [7:0] push_data_q;
   wire fifo_ready, fifo_valid;
   wire [7:0] fifo_data;

   // Depth fill stalls nothing: while done is set, later bytes never enter
   byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(3)) u_rx_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(push_q),
      .in_ready(fifo_ready),
      .in_data(push_data_q),
      .out_valid(fifo_valid),
      .out_ready(run_en),
      .out_data(fifo_data)
   );

   // ************************************************************
   // Shift engine
   // ************************************************************
   localparam ST_IDLE = 2'd0;
   localparam ST_RUN = 2'd1;

   reg [1:0] state_q;
   reg [7:0] shreg_q;
   reg [4:0] edge_cnt_q;
   reg in_bit_q;
   reg slv_armed_q;
   reg done_arm_q, mode_fault_flag_arm_q;

   wire slv_sel = en && !mst && ss_low; // Deselected slave ignores clock
   wire s_edge = slv_sel && (sck_i != sck_prev_q);
   wire m_edge = m_tick && busy && mst;
   wire any_edge = m_edge || s_edge;
   // Collision windows per mode
   wire coll = busy || (!mst && ss_low && en && !cpha) || (!mst && slv_armed_q);
   wire wr_ok = data_wr && !done_f && !coll; // Done refuses writes
   // Odd edges capture under phase zero, even edges under phase one
   wire cap_edge = any_edge && (edge_cnt_q[0] == cpha);
   // Master phase one ends on a seventeenth tick, once the last bit is past the pin delay
   wire last_edge = any_edge && (edge_cnt_q == ((mst && cpha) ? 5'd16 : 5'd15));
   // Master takes its bit at the launch edge, at least two cycles after capture
   wire in_now = mst ? miso_s_q[1] : in_bit_q;
   wire [7:0] rx_full = {shreg_q[6:0], (cpha && !mst) ? mosi_s_q[1] : in_now};

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         shreg_q <= 8'h00;
         edge_cnt_q <= 5'd0;
         in_bit_q <= 1'b0;
         busy <= 1'b0;
         slv_armed_q <= 1'b0;
         push_q <= 1'b0;
         push_data_q <= 8'h00;
         sck_out <= 1'b0;
         mosi_out <= 1'b0;
         miso_out <= 1'b0;
      end else if (run_en) begin
         push_q <= 1'b0;
         if (!en || (!mst && !ss_low)) begin
            slv_armed_q <= 1'b0;
         end
         case (state_q)
            ST_IDLE: begin
               sck_out <= cpol; // Clock rests at idle level
               edge_cnt_q <= 5'd0;
               if (wr_ok) begin
                  shreg_q <= wr_data; // Write only when no transfer or lock
                  mosi_out <= cpha ? mosi_out : wr_data[7];
                  miso_out <= cpha ? miso_out : wr_data[7];
               end
               if (wr_ok && mst && en) begin
                  busy <= 1'b1; // Only a data write starts master
                  state_q <= ST_RUN;
               end else if (slv_sel) begin
                  if (!cpha) begin
                     miso_out <= shreg_q[7];
                  end
                  if (s_edge) begin
                     busy <= 1'b1;
                     slv_armed_q <= 1'b1;
                     state_q <= ST_RUN;
                     edge_cnt_q <= 5'd1;
                     if (cpha) begin
                        miso_out <= shreg_q[7]; // First edge drives top bit
                     end else begin
                        in_bit_q <= mosi_s_q[1];
                     end
                  end
               end
            end
            ST_RUN: begin
               if (m_edge && edge_cnt_q != 5'd16) begin
                  sck_out <= !sck_out;
               end
               if (!en || (!mst && !ss_low)) begin
                  busy <= 1'b0; // Aborted by disable or deselect
                  state_q <= ST_IDLE;
               end else if (any_edge) begin
                  edge_cnt_q <= edge_cnt_q + 5'd1;
                  if (cap_edge) begin
                     in_bit_q <= mst ? miso_s_q[1] : mosi_s_q[1];
                  end else if (edge_cnt_q != 5'd0) begin
                     // Launch edge: shift captured bit in, next bit out
                     shreg_q <= {shreg_q[6:0], in_now};
                     mosi_out <= shreg_q[6];
                     miso_out <= shreg_q[6];
                  end else begin
                     mosi_out <= shreg_q[7]; // Phase one master: top bit on edge zero
                  end
                  if (last_edge) begin
                     // Sixteen edges make eight pulses
                     busy <= 1'b0;
                     state_q <= ST_IDLE;
                     push_q <= !done_f; // Later bytes lost on overrun
                     push_data_q <= rx_full;
                     shreg_q <= rx_full;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Control and status with clearing sequences
   // ************************************************************
   wire fault = en && mst && ss_low; // Never in slave mode

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         control_reg <= `CTL_RESET_VAL;
         status_reg <= `STS_RESET_VAL;
         done_arm_q <= 1'b0;
         mode_fault_flag_arm_q <= 1'b0;
         rx_byte <= 8'h00;
      end else if (run_en) begin
         if (fifo_valid) begin
            rx_byte <= fifo_data; // CPU-synchronous read buffer
         end
         if (status_acc && done_f) done_arm_q <= 1'b1;
         if (status_acc && mode_fault_flag_f) mode_fault_flag_arm_q <= 1'b1;
         if (status_acc && status_reg[`STS_WRITE_COLLISION_FLAG_BIT]) done_arm_q <= 1'b1;
         // Done: status access then data access, set wins
         if (push_q) begin
            status_reg[`STS_DONE_BIT] <= 1'b1;
         end else if (done_arm_q && (data_rd || data_wr)) begin
            status_reg[`STS_DONE_BIT] <= 1'b0;
            status_reg[`STS_WRITE_COLLISION_FLAG_BIT] <= 1'b0; // Same sequence clears collision
            done_arm_q <= 1'b0;
         end
         // Collision set comes after the clear so it wins
         if (data_wr && (coll || (done_f && !done_arm_q))) begin
            status_reg[`STS_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
         end
         // Control write; fault blocks enable and master unless clearing
         if (ctrl_wr) begin
            control_reg <= mode_fault_flag_f && !mode_fault_flag_arm_q ? (wr_data & 8'haf) : wr_data;
         end
         if (ctrl_wr && mode_fault_flag_arm_q && !fault) begin
            status_reg[`STS_MODE_FAULT_FLAG_BIT] <= 1'b0;
            mode_fault_flag_arm_q <= 1'b0;
         end
         if (fault) begin
            status_reg[`STS_MODE_FAULT_FLAG_BIT] <= 1'b1;
            control_reg[`CTL_PERIPH_EN_BIT] <= 1'b0;
            control_reg[`CTL_MASTER_BIT] <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Pin enables and interrupt request
   // ************************************************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_oe_n <= 1'b1;
         mosi_oe_n <= 1'b1;
         miso_oe_n <= 1'b1;
         irq <= 1'b0;
         wake <= 1'b0;
      end else begin
         sck_oe_n <= !(en && mst);
         mosi_oe_n <= !(en && mst);
         miso_oe_n <= !(en && !mst && ss_low);
         // Collision flag deliberately left out of the request
         irq <= control_reg[`CTL_IRQ_EN_BIT] && (done_f || mode_fault_flag_f) && !global_mask;
         wake <= wait_mode && control_reg[`CTL_IRQ_EN_BIT] && (done_f || mode_fault_flag_f);
      end
   end

endmodule // spi_xfer

`default_nettype wire

// >>> tb/spi_xfer_sva.sv
// Checker for the SPI transfer engine ports
`timescale 1ns/10ps
`default_nettype none

module spi_xfer_chk (
   input wire logic clk, // CPU clock
   input wire logic rstn, // Async reset, active low
   input wire logic data_wr, // Data write strobe
   input wire logic ctrl_wr, // Control write strobe
   input wire logic status_acc, // Status access strobe
   input wire logic global_mask, // Global interrupt mask
   input wire logic halt_mode, // Freeze request
   input wire logic [7:0] control_reg, // Control image
   input wire logic [7:0] status_reg, // Status image
   input wire logic irq, // Interrupt request
   input wire logic sck_out, // Serial clock out
   input wire logic miso_oe_n, // MISO enable, low drives
   input wire logic ss_n_in, // Slave select pin
   input wire logic busy // Byte in progress
);
   logic [6:0] gap_q;
   logic sck_q;
   logic seen_q;
   logic acc_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // Expected half period per rate code; 3'b101 is not a listed rate
   function automatic [6:0] half_of(input [2:0] code);
      case (code)
         3'b100: half_of = 7'h02;
         3'b000: half_of = 7'h04;
         3'b001: half_of = 7'h08;
         3'b110: half_of = 7'h10;
         3'b010: half_of = 7'h20;
         default: half_of = 7'h40;
      endcase
   endfunction

   // Gap since the last clock toggle, and status access seen during a fault
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_q <= 7'h00;
         sck_q <= 1'b0;
         seen_q <= 1'b0;
         acc_q <= 1'b0;
      end else begin
         sck_q <= sck_out;
         gap_q <= (!busy || sck_out != sck_q) ? 7'h00 : gap_q + 7'h01;
         seen_q <= busy && (seen_q || sck_out != sck_q);
         acc_q <= status_reg[4] && (acc_q || (status_acc && !halt_mode));
      end
   end

   rate_gap_a: assert property (busy && seen_q && sck_out != sck_q &&
      {control_reg[5], control_reg[1:0]} != 3'b101 |->
      gap_q == half_of({control_reg[5], control_reg[1:0]}) - 7'h01)
      else $error("serial clock half period wrong");
   sck_idle_a: assert property (control_reg[6] && control_reg[4] && !busy &&
      $stable(control_reg) |-> sck_out == control_reg[3]) else $error("clock not idle");
   busy_start_a: assert property (data_wr && !busy && control_reg[6] && control_reg[4] &&
      !status_reg[7] && !status_reg[4] && !halt_mode |=> busy) else $error("byte not started");
   write_collision_flag_set_a: assert property (data_wr && busy && !halt_mode |=> status_reg[6])
      else $error("collision not flagged");
   irq_cause_a: assert property (irq |-> status_reg[7] || status_reg[4] ||
      $past(status_reg[7]) || $past(status_reg[4])) else $error("request without event");
   mask_block_a: assert property (global_mask && $past(global_mask) |-> !irq)
      else $error("request passed the mask");
   irq_raise_a: assert property (control_reg[7] && !global_mask && status_reg[7] &&
      !halt_mode |-> ##[0:2] irq) else $error("request missing");
   fault_drop_a: assert property ($rose(status_reg[4]) |->
      ##[0:2] !(control_reg[6] || control_reg[4])) else $error("fault kept enable");
   fault_master_a: assert property ($rose(status_reg[4]) |-> $past(control_reg[4]))
      else $error("fault set in slave mode");
   ctrl_refuse_a: assert property (ctrl_wr && status_reg[4] && !acc_q && !status_acc &&
      !halt_mode |=> !control_reg[6] && !control_reg[4]) else $error("enable set in fault");
   halt_freeze_a: assert property ($past(halt_mode) |->
      $stable(control_reg) && $stable(status_reg)) else $error("registers moved in halt");
   miso_quiet_a: assert property (!control_reg[4] && ss_n_in && $past(ss_n_in) &&
      $past(ss_n_in, 2) && $past(ss_n_in, 3) && $past(ss_n_in, 4) |-> miso_oe_n)
      else $error("deselected slave drives");

   done_c: cover property ($fell(busy));
   write_collision_flag_c: cover property ($rose(status_reg[6]));
   fault_c: cover property ($rose(status_reg[4]));
endmodule // spi_xfer_chk

bind spi_xfer spi_xfer_chk u_spi_xfer_chk (.clk(clk), .rstn(rstn), .data_wr(data_wr),
   .ctrl_wr(ctrl_wr), .status_acc(status_acc), .global_mask(global_mask),
   .halt_mode(halt_mode), .control_reg(control_reg), .status_reg(status_reg), .irq(irq),
   .sck_out(sck_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in), .busy(busy));
`default_nettype wire

// >>> tb/spi_slave_model.sv
// Behavioural external SPI slave facing the engine in master mode
`timescale 1ns/10ps
`default_nettype none

module spi_slave_model #(
   parameter real RESP_NS = 1.0 // Output delay after a launch edge
) (
   input wire logic sck, // Serial clock from master
   input wire logic mosi, // Data from master
   input wire logic sel_n, // Select, active low
   input wire logic cpol, // Clock polarity
   input wire logic cpha, // Clock phase
   input wire logic [7:0] tx, // Byte to send
   output logic miso, // Data to master
   output logic [7:0] rx // Byte received
);
   int edges = 0;
   logic [7:0] sh = 8'h00;
   initial miso = 1'b0;
   initial rx = 8'h00;

   // Phase zero puts the top bit out on select, before any edge
   always @(negedge sel_n) begin
      edges = 0;
      sh = tx;
      if (!cpha) #RESP_NS miso = sh[7];
   end

   // Released line shows the inverse so a stale bit never matches
   always @(posedge sel_n) #RESP_NS miso = ~miso;

   // Odd edges capture for phase zero, even edges for phase one
   always @(sck) begin
      if (!sel_n) begin
         edges++;
         if ((edges % 2 == 1) != cpha) begin
            rx = {rx[6:0], mosi};
         end else begin
            if (!(cpha && edges == 1)) sh = {sh[6:0], 1'b0};
            #RESP_NS miso = sh[7];
         end
      end
   end
endmodule // spi_slave_model
`default_nettype wire

// >>> tb/spi_xfer_bench.sv
// Self-checking bench for the SPI transfer engine
`timescale 1ns/10ps
`default_nettype none

module spi_xfer_bench;
   logic clk = 0, rstn = 0, global_mask = 1, halt_mode = 0, wait_mode = 0;
   logic ss_n_in = 1, sel_n = 1, counting = 0; // Select pin starts high; the fault and slave tests drive it low
   logic data_wr = 0, data_rd = 0, ctrl_wr = 0, status_acc = 0;
   logic [7:0] wr_data = 8'h00, tx_s = 8'h00;
   wire [7:0] rx_byte, control_reg, status_reg, rx_s;
   wire irq, wake, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, busy, miso_s;
   wire sck_w = sck_oe_n ? control_reg[3] : sck_out;
   wire mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
   wire miso_w = miso_oe_n ? miso_s : miso_out;
   int fails = 0, n_compared = 0, edges = 0, cycles = 0;
   logic [2:0] rates [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};

   always #5 clk = ~clk;

   spi_xfer u_spi_xfer (.clk(clk), .rstn(rstn), .wr_data(wr_data), .data_wr(data_wr),
      .data_rd(data_rd), .ctrl_wr(ctrl_wr), .status_acc(status_acc),
      .global_mask(global_mask), .halt_mode(halt_mode), .wait_mode(wait_mode),
      .rx_byte(rx_byte), .control_reg(control_reg), .status_reg(status_reg), .irq(irq),
      .wake(wake), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w),
      .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out),
      .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in), .busy(busy));

   spi_slave_model u_spi_slave_model (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n),
      .cpol(control_reg[3]), .cpha(control_reg[2]), .tx(tx_s), .miso(miso_s), .rx(rx_s));

   // Clock edge counter during a byte, and a cycle ceiling against hangs
   always @(sck_out) if (counting) edges++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         test_done();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle strobe: 0 data write, 1 data read, 2 control write, 3 status access
   task automatic strobe(input int k, input logic [7:0] d);
      @(posedge clk);
      #1;
      wr_data = d;
      case (k)
         0: data_wr = 1;
         1: data_rd = 1;
         2: ctrl_wr = 1;
         default: status_acc = 1;
      endcase
      @(posedge clk);
      #1;
      {data_wr, data_rd, ctrl_wr, status_acc} = 4'h0;
   endtask

   task automatic clear_done;
      strobe(3, 8'h00);
      strobe(1, 8'h00);
   endtask

   // Full master byte against the slave model
   task automatic xfer(input logic [7:0] cfg, input logic [7:0] m, input logic [7:0] s);
      tx_s = s;
      strobe(2, cfg);
      repeat (2) @(posedge clk); // Idle level settles before select falls
      #1 sel_n = 0;
      edges = 0;
      counting = 1;
      strobe(0, m);
      repeat (2) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      repeat (3) @(posedge clk);
      #1;
      counting = 0;
      check("edges", edges[7:0], 8'h10);
      check("done", status_reg & 8'h80, 8'h80);
      check("rx_byte", rx_byte, s);
      check("slave rx", rx_s, m);
      check("sck idle", {7'h00, sck_out}, {7'h00, cfg[3]});
      sel_n = 1;
   endtask

   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (5) @(posedge clk);
      #1 rstn = 1;
      check("status reset", status_reg, 8'h00);
      check("miso release", {7'h00, miso_oe_n}, 8'h01);
      for (int i = 0; i < 6; i++) begin
         xfer({2'b01, rates[i][2], 1'b1, i[1:0], rates[i][1:0]}, 8'ha5 ^ i[7:0], 8'h3c + i[7:0]);
         clear_done();
         check("cleared", status_reg, 8'h00);
      end
      // Write during a byte, then a write while done stands
      fork
         xfer(8'h50, 8'h96, 8'h69);
         begin
            repeat (10) @(posedge clk);
            strobe(0, 8'hff);
         end
      join
      check("write_collision_flag", status_reg & 8'h40, 8'h40);
      strobe(0, 8'h11);
      check("refused", {7'h00, busy}, 8'h00);
      clear_done();
      check("write_collision_flag clear", status_reg, 8'h00);
      // Request gating and wake
      xfer(8'hd0, 8'h0f, 8'hf0);
      check("masked", {7'h00, irq}, 8'h00);
      global_mask = 0;
      wait_mode = 1;
      repeat (3) @(posedge clk);
      #1;
      check("irq", {7'h00, irq}, 8'h01);
      check("wake", {7'h00, wake}, 8'h01);
      clear_done();
      repeat (3) @(posedge clk);
      #1;
      check("irq low", {7'h00, irq}, 8'h00);
      wait_mode = 0;
      global_mask = 1;
      // Halt freezes the control register
      halt_mode = 1;
      strobe(2, 8'h00);
      check("halt", control_reg, 8'hd0);
      halt_mode = 0;
      // Mode fault and its clearing sequence
      strobe(2, 8'h50);
      ss_n_in = 0;
      repeat (6) @(posedge clk);
      #1;
      check("fault", status_reg & 8'h10, 8'h10);
      check("forced", control_reg & 8'h50, 8'h00);
      ss_n_in = 1;
      strobe(2, 8'h50);
      check("refuse", control_reg & 8'h50, 8'h00);
      check("fault kept", status_reg & 8'h10, 8'h10);
      strobe(3, 8'h00);
      strobe(2, 8'h50);
      check("fault clear", status_reg & 8'h10, 8'h00);
      check("restored", control_reg, 8'h50);
      // Phase-zero slave with select low refuses data writes
      strobe(2, 8'h40);
      ss_n_in = 0;
      repeat (4) @(posedge clk);
      strobe(0, 8'h55);
      check("slave write_collision_flag", status_reg & 8'h40, 8'h40);
      check("no fault", status_reg & 8'h10, 8'h00);
      ss_n_in = 1;
      test_done();
   end
endmodule // spi_xfer_bench
`default_nettype wire
